// File: design/sswd_pkg.sv
/*
  sswd_pkg: constants for the slave state and watchdog block.
  assumes: a single 100 MHz clock domain; no software-visible registers.
*/
`default_nettype none
package sswd_pkg;
  // slave states
  typedef enum logic [2:0] {
    ST_INIT,
    ST_PREOP,
    ST_SAFEOP,
    ST_OP,
    ST_BOOT
  } sswd_state_t;
  // requested state codes on the request port
  localparam logic [2:0] REQ_INIT = 3'h1;
  localparam logic [2:0] REQ_PREOP = 3'h2;
  localparam logic [2:0] REQ_BOOT = 3'h3;
  localparam logic [2:0] REQ_SAFEOP = 3'h4;
  localparam logic [2:0] REQ_OP = 3'h5;
  // watchdog timing: base clock 25 MHz, system clock 100 MHz
  localparam int SYS_CLK_MHZ = 100;
  localparam int BASE_CLK_MHZ = 25;
  localparam logic [2:0] BASE_DIV = 3'(SYS_CLK_MHZ / BASE_CLK_MHZ);
  localparam logic [15:0] MULT_RST = 16'h09C2; // 2498 -> 100 us base tick
  localparam logic [15:0] MULT_MIN = 16'h0001;
  localparam logic [15:0] WD_TIME_RST = 16'h03E8; // 1000 ticks -> 100 ms
  // mailbox protocol code for file access
  localparam logic [3:0] MBX_FILE = 4'h4;
  // object dictionary ranges (upper index nibble)
  localparam logic [3:0] OD_IDENT = 4'h1;
  localparam logic [3:0] OD_LEGACY = 4'h4;
  localparam logic [3:0] OD_INPUT = 4'h6;
  localparam logic [3:0] OD_OUTPUT = 4'h7;
  localparam logic [3:0] OD_CHAN = 4'h8;
  localparam int OD_CHAN_ENTRIES = 16;
  localparam logic [31:0] DEV_TYPE = 32'h00000123; // arbitrary value
  // object access attribute codes
  localparam logic [1:0] ACC_RO = 2'h0;
  localparam logic [1:0] ACC_RW = 2'h1;
  localparam logic [1:0] ACC_NONE = 2'h2;
endpackage
`default_nettype wire

// File: design/sswd_top.sv
/*
  sswd_top: slave state machine, sync manager watchdog and object dictionary access.
  assumes: all inputs come from logic on the same clock; master keeps its own duties.
*/
// How it works
// [R1] base tick every multiplier plus two periods
// [R2] time 0..65535, multiplier 1..65535 accepted
// [R3] monitoring defaults to 100 ms
// [R4] expiry with outputs active clears outputs
// [R5] setting zero disables watchdog entirely
// [R6] each process data access restarts count
// [R7] power-up enters init, no traffic allowed
// [R8] master configures channels 0,1 in init
// [R9] init to preop checks mailbox setup
// [R10] preop allows mailbox only; master configures pd
// [R11] preop to safeop checks pd, clocks, latches inputs
// [R12] safeop: traffic allowed, outputs held safe
// [R13] disabled watchdog lets safeop drive outputs
// [R14] master gives valid outputs before op
// [R15] op copies master outputs to pins
// [R16] boot entered only from init
// [R17] boot allows file mailbox only
// [R18] objects use 16-bit index, 8-bit subindex
// [R19] identity at 0x1000, channel params 0x8000
// [R20] inputs at 0x6000, outputs at 0x7000
// [R21] 0x4000 mirrors 0x8000 channel params
// [R22] access only as attribute allows
// [R23] failed entry check refuses, flags error
`default_nettype none
module sswd_top (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_srst, // synchronous reset, active high
  input wire logic i_req_vld, // state change request pulse
  input wire logic [2:0] i_req_state, // requested state code
  input wire logic i_err_ack, // clears error flag
  input wire logic i_mbx_cfg_ok, // mailbox channels 0/1 set correctly
  input wire logic i_pd_cfg_ok, // process data channels set correctly
  input wire logic i_dc_cfg_ok, // clock settings correct
  input wire logic i_wd_load, // load watchdog settings pulse
  input wire logic [15:0] i_wd_mult, // multiplier setting
  input wire logic [15:0] i_wd_time, // watchdog time setting
  input wire logic i_pd_access, // successful process data access pulse
  input wire logic [7:0] i_pd_out, // master output data
  input wire logic [7:0] i_phys_in, // physical input levels
  input wire logic i_mbx_vld, // mailbox message pulse
  input wire logic [3:0] i_mbx_proto, // mailbox protocol code
  input wire logic i_od_vld, // object access request pulse
  input wire logic i_od_wr, // 1 write, 0 read
  input wire logic [15:0] i_od_index, // object index
  input wire logic [7:0] i_od_sub, // object subindex
  input wire logic [31:0] i_od_wdata, // write data
  output logic [2:0] o_state, // current state
  output logic o_err, // transition refused flag
  output logic o_wd_fired, // watchdog expired flag
  output logic [7:0] o_phys_out, // physical outputs
  output logic [7:0] o_in_shadow, // inputs copy for master
  output logic o_mbx_acc, // mailbox accepted pulse
  output logic o_mbx_rej, // mailbox rejected pulse
  output logic o_pd_rej, // process data rejected pulse
  output logic o_od_ack, // object access done pulse
  output logic o_od_abort, // object access refused pulse
  output logic [31:0] o_od_rdata // read data
);
  sswd_pkg::sswd_state_t state_ff;
  logic err_ff, wd_fired_ff, mbx_acc_ff, mbx_rej_ff, pd_rej_ff;
  logic od_ack_ff, od_abort_ff;
  logic [7:0] phys_out_ff, in_shadow_ff;
  logic [31:0] od_rdata_ff;
  localparam int OD_CHAN_ENTRIES = sswd_pkg::OD_CHAN_ENTRIES;
  localparam logic [2:0] BASE_DIV_M1 = sswd_pkg::BASE_DIV - 3'h1;
  logic [15:0] mult_ff, wd_time_ff, wd_cnt_ff;
  logic [16:0] base_cnt_ff, base_last;
  logic [2:0] div_ff;
  logic base_tick;
  logic pd_allowed, outs_live;
  logic [31:0] chan_ff [OD_CHAN_ENTRIES];

  // access attribute per index range
  function automatic logic [1:0] od_attr(input logic [15:0] idx);
    case (idx[15:12])
      sswd_pkg::OD_IDENT: od_attr = sswd_pkg::ACC_RO;
      sswd_pkg::OD_INPUT: od_attr = sswd_pkg::ACC_RO;
      sswd_pkg::OD_OUTPUT: od_attr = sswd_pkg::ACC_RO;
      sswd_pkg::OD_LEGACY: od_attr = sswd_pkg::ACC_RW;
      sswd_pkg::OD_CHAN: od_attr = sswd_pkg::ACC_RW;
      default: od_attr = sswd_pkg::ACC_NONE;
    endcase
  endfunction

  // state transitions with entry checks
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      // [R7] start in init
      state_ff <= sswd_pkg::ST_INIT;
      err_ff <= 1'b0;
    end else begin
      if (i_err_ack) begin
        err_ff <= 1'b0;
      end
      if (i_req_vld) begin
        // [R23] refuse, flag error (set wins over ack)
        case (i_req_state)
          sswd_pkg::REQ_INIT: state_ff <= sswd_pkg::ST_INIT;
          sswd_pkg::REQ_PREOP: begin
            // [R9] check mailbox setup
            if ((state_ff == sswd_pkg::ST_INIT || state_ff == sswd_pkg::ST_PREOP ||
                 state_ff == sswd_pkg::ST_SAFEOP || state_ff == sswd_pkg::ST_OP) &&
                (state_ff != sswd_pkg::ST_INIT || i_mbx_cfg_ok)) begin
              state_ff <= sswd_pkg::ST_PREOP;
            end else begin
              err_ff <= 1'b1;
            end
          end
          sswd_pkg::REQ_BOOT: begin
            // [R16] boot only from init
            if (state_ff == sswd_pkg::ST_INIT || state_ff == sswd_pkg::ST_BOOT) begin
              state_ff <= sswd_pkg::ST_BOOT;
            end else begin
              err_ff <= 1'b1;
            end
          end
          sswd_pkg::REQ_SAFEOP: begin
            // [R11] check pd and clock setup
            if (state_ff == sswd_pkg::ST_PREOP && i_pd_cfg_ok && i_dc_cfg_ok) begin
              state_ff <= sswd_pkg::ST_SAFEOP;
            end else if (state_ff == sswd_pkg::ST_OP || state_ff == sswd_pkg::ST_SAFEOP) begin
              state_ff <= sswd_pkg::ST_SAFEOP;
            end else begin
              err_ff <= 1'b1;
            end
          end
          sswd_pkg::REQ_OP: begin
            if (state_ff == sswd_pkg::ST_SAFEOP || state_ff == sswd_pkg::ST_OP) begin
              state_ff <= sswd_pkg::ST_OP;
            end else begin
              err_ff <= 1'b1;
            end
          end
          default: err_ff <= 1'b1;
        endcase
      end
    end
  end

  // [R10] process data only in safeop and op
  assign pd_allowed = (state_ff == sswd_pkg::ST_SAFEOP) || (state_ff == sswd_pkg::ST_OP);
  // [R13] safeop drives outputs when watchdog off
  assign outs_live = (state_ff == sswd_pkg::ST_OP) ||
                     (state_ff == sswd_pkg::ST_SAFEOP && wd_time_ff == 16'h0000);

  // watchdog settings, out-of-range multiplier clamped to minimum
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      // [R3] default 100 ms
      mult_ff <= sswd_pkg::MULT_RST;
      wd_time_ff <= sswd_pkg::WD_TIME_RST;
    end else if (i_wd_load) begin
      // [R2] accept full ranges
      mult_ff <= (i_wd_mult < sswd_pkg::MULT_MIN) ? sswd_pkg::MULT_MIN : i_wd_mult;
      wd_time_ff <= i_wd_time;
    end
  end

  // last base count of a tick; 17 bits so the top multiplier does not wrap
  assign base_last = {1'b0, mult_ff} + 17'h00001;
  // [R1] base tick: 25 MHz divided by multiplier + 2
  always_ff @(posedge i_clk) begin
    if (i_srst || i_wd_load) begin
      div_ff <= 3'h0;
      base_cnt_ff <= 17'h00000;
    end else if (div_ff == BASE_DIV_M1) begin
      div_ff <= 3'h0;
      base_cnt_ff <= (base_cnt_ff == base_last) ? 17'h00000 : base_cnt_ff + 17'h00001;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end
  assign base_tick = (div_ff == BASE_DIV_M1) && (base_cnt_ff == base_last);

  // watchdog counter and expiry
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wd_cnt_ff <= 16'h0000;
      wd_fired_ff <= 1'b0;
    end else if (i_pd_access && pd_allowed) begin
      // [R6] restart on pd access
      wd_cnt_ff <= 16'h0000;
      wd_fired_ff <= 1'b0;
    end else if (wd_time_ff == 16'h0000) begin
      // [R5] zero disables monitoring
      wd_cnt_ff <= 16'h0000;
      wd_fired_ff <= 1'b0;
    end else if (base_tick && !wd_fired_ff) begin
      // [R4] expiry after setting ticks
      if (wd_cnt_ff + 16'h0001 >= wd_time_ff) begin
        wd_fired_ff <= 1'b1;
      end else begin
        wd_cnt_ff <= wd_cnt_ff + 16'h0001;
      end
    end
  end

  // physical outputs and input shadow
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      phys_out_ff <= 8'h00;
      in_shadow_ff <= 8'h00;
    end else begin
      // [R12] inputs refreshed in safeop and op
      if (pd_allowed) begin
        in_shadow_ff <= i_phys_in;
      end else if (i_req_vld && i_req_state == sswd_pkg::REQ_SAFEOP &&
                   state_ff == sswd_pkg::ST_PREOP) begin
        // [R11] latch inputs before acknowledging
        in_shadow_ff <= i_phys_in;
      end
      // [R4] clear outputs on expiry
      if (!outs_live || wd_fired_ff) begin
        phys_out_ff <= 8'h00;
      end else if (i_pd_access) begin
        // [R15] copy master output data
        phys_out_ff <= i_pd_out;
      end
    end
  end

  // mailbox and process data gating
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mbx_acc_ff <= 1'b0;
      mbx_rej_ff <= 1'b0;
      pd_rej_ff <= 1'b0;
    end else begin
      mbx_acc_ff <= 1'b0;
      mbx_rej_ff <= 1'b0;
      if (i_mbx_vld) begin
        // [R17] boot takes file access only
        if (state_ff == sswd_pkg::ST_INIT ||
            (state_ff == sswd_pkg::ST_BOOT && i_mbx_proto != sswd_pkg::MBX_FILE)) begin
          mbx_rej_ff <= 1'b1;
        end else begin
          mbx_acc_ff <= 1'b1;
        end
      end
      // [R10] pd refused outside safeop/op
      pd_rej_ff <= i_pd_access && !pd_allowed;
    end
  end

  // object dictionary access
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      od_ack_ff <= 1'b0;
      od_abort_ff <= 1'b0;
      od_rdata_ff <= 32'h00000000;
      for (int k = 0; k < OD_CHAN_ENTRIES; k++) begin
        chan_ff[k] <= 32'h00000000;
      end
    end else begin
      od_ack_ff <= 1'b0;
      od_abort_ff <= 1'b0;
      if (i_od_vld) begin
        // [R22] check access attribute
        if (state_ff == sswd_pkg::ST_INIT || state_ff == sswd_pkg::ST_BOOT ||
            od_attr(i_od_index) == sswd_pkg::ACC_NONE ||
            (i_od_wr && od_attr(i_od_index) == sswd_pkg::ACC_RO)) begin
          od_abort_ff <= 1'b1;
        end else begin
          od_ack_ff <= 1'b1;
          // [R18] index and subindex decode
          case (i_od_index[15:12])
            // [R19] identity range
            sswd_pkg::OD_IDENT: od_rdata_ff <= sswd_pkg::DEV_TYPE;
            // [R20] process data ranges
            sswd_pkg::OD_INPUT: od_rdata_ff <= {24'h000000, in_shadow_ff};
            sswd_pkg::OD_OUTPUT: od_rdata_ff <= {24'h000000, phys_out_ff};
            default: begin
              // [R21] legacy and channel ranges share storage
              od_rdata_ff <= chan_ff[i_od_sub[3:0]];
              if (i_od_wr) begin
                chan_ff[i_od_sub[3:0]] <= i_od_wdata;
              end
            end
          endcase
        end
      end
    end
  end

  assign o_state = state_ff;
  assign o_err = err_ff;
  assign o_wd_fired = wd_fired_ff;
  assign o_phys_out = phys_out_ff;
  assign o_in_shadow = in_shadow_ff;
  assign o_mbx_acc = mbx_acc_ff;
  assign o_mbx_rej = mbx_rej_ff;
  assign o_pd_rej = pd_rej_ff;
  assign o_od_ack = od_ack_ff;
  assign o_od_abort = od_abort_ff;
  assign o_od_rdata = od_rdata_ff;
endmodule
`default_nettype wire

// File: bench/sswd_top_monitor.sv
/*
  sswd_top_monitor: port checks for sswd_top.
  assumes: bound to sswd_top; one clock, sync reset.
*/
`default_nettype none
module sswd_top_monitor (
  input wire logic i_clk, // clock
  input wire logic i_srst, // reset
  input wire logic i_req_vld, // request
  input wire logic [2:0] i_req_state, // code
  input wire logic i_mbx_cfg_ok, // mbx ok
  input wire logic i_pd_access, // pd access
  input wire logic [7:0] i_pd_out, // pd data
  input wire logic i_mbx_vld, // mbx msg
  input wire logic [3:0] i_mbx_proto, // protocol
  input wire logic i_od_vld, // od request
  input wire logic [2:0] o_state, // state
  input wire logic o_err, // error
  input wire logic o_wd_fired, // fired
  input wire logic [7:0] o_phys_out, // outputs
  input wire logic o_mbx_acc, // mbx accept
  input wire logic o_mbx_rej, // mbx reject
  input wire logic o_pd_rej, // pd reject
  input wire logic o_od_ack, // od done
  input wire logic o_od_abort // od refused
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // refused preop request and its outcome
  sequence bad_preop_s;
    i_req_vld && i_req_state == sswd_pkg::REQ_PREOP && o_state == 3'h0 && !i_mbx_cfg_ok;
  endsequence
  sequence held_s;
    o_err && o_state == 3'h0;
  endsequence
  reset_init_a: assert property (
    disable iff (1'b0) i_srst |=> o_state == 3'h0 && o_phys_out == 8'h00) else $error("reset");
  init_mbx_a: assert property (
    o_state == 3'h0 && i_mbx_vld |=> o_mbx_rej && !o_mbx_acc) else $error("init mbx");
  preop_pd_a: assert property (
    o_state == 3'h1 && i_pd_access |=> o_pd_rej) else $error("preop pd");
  boot_entry_a: assert property (
    o_state == 3'h4 && $past(o_state) != 3'h4 |-> $past(o_state) == 3'h0) else $error("boot");
  boot_mbx_a: assert property (
    o_state == 3'h4 && i_mbx_vld |=> o_mbx_acc == ($past(i_mbx_proto) == sswd_pkg::MBX_FILE))
    else $error("boot mbx");
  preop_check_a: assert property (
    bad_preop_s |=> held_s) else $error("preop check");
  op_copy_a: assert property (
    o_state == 3'h3 && !o_wd_fired && i_pd_access && !i_req_vld |=> o_phys_out == $past(i_pd_out))
    else $error("op copy");
  wd_clear_a: assert property (
    $rose(o_wd_fired) |-> ##[0:1] o_phys_out == 8'h00) else $error("wd clear");
  od_answer_a: assert property (
    i_od_vld |=> o_od_ack != o_od_abort) else $error("od answer");
endmodule
`default_nettype wire

// File: bench/sswd_master_model.sv
/*
  sswd_master_model: master stand-in for requests, process data, mailbox.
  assumes: tasks called from the bench; inputs taken on rising edges.
*/
`default_nettype none
module sswd_master_model (
  input wire logic i_clk, // clock
  output logic o_req_vld = 1'b0, // request
  output logic [2:0] o_req_state = 3'h0, // code
  output logic o_pd_access = 1'b0, // pd access
  output logic [7:0] o_pd_out = 8'h00, // pd data
  output logic o_mbx_vld = 1'b0, // mbx msg
  output logic [3:0] o_mbx_proto = 4'h0 // protocol
);
  timeunit 1ns;
  timeprecision 1ps;
  // state request for one edge; released code inverts
  task automatic req(input logic [2:0] c);
    @(posedge i_clk) #1;
    o_req_vld = 1'b1;
    o_req_state = c;
    @(posedge i_clk) #1;
    o_req_vld = 1'b0;
    o_req_state = ~c;
  endtask
  task automatic pd(input logic [7:0] d);
    @(posedge i_clk) #1;
    o_pd_access = 1'b1;
    o_pd_out = d;
    @(posedge i_clk) #1;
    o_pd_access = 1'b0;
    o_pd_out = ~d;
  endtask
  // mailbox message of one protocol
  task automatic mbx(input logic [3:0] p);
    @(posedge i_clk) #1;
    o_mbx_vld = 1'b1;
    o_mbx_proto = p;
    @(posedge i_clk) #1;
    o_mbx_vld = 1'b0;
    o_mbx_proto = ~p;
  endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
/*
  testbench: drives sswd_top through the master model, checks answers.
  assumes: design package and top compiled first.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [37:0] DAT = 38'h2000000000, ACK = 38'h1000000000, ABT = 38'h0800000000;
  localparam logic [37:0] MACC = 38'h0400000000, MREJ = 38'h0200000000, PREJ = 38'h0100000000;
  logic clk = 1'b0, srst = 1'b1, ack = 1'b0, ld = 1'b0, ov = 1'b0, ow = 1'b0;
  logic mok = 1'b0, pok = 1'b0, dok = 1'b0, rv, pa, mv, fired, err, oa, ob, ma, mr, pr;
  logic [15:0] mult = 16'h0001, wt = 16'h0002, oi = 16'h0000;
  logic [7:0] pin = 8'h00, os = 8'h00, po, pout, sh, d;
  logic [31:0] owd = 32'h0, rd;
  logic [2:0] rs, st;
  logic [3:0] mp;
  logic [37:0] e;
  logic [37:0] q[$];
  logic [2:0] bad[6] = '{3'h2, 3'h4, 3'h5, 3'h0, 3'h6, 3'h7};
  int mismatches = 0, n_compared = 0, seed = 84, cyc = 0, n;
  sswd_master_model i_sswd_master_model (.i_clk(clk), .o_req_vld(rv), .o_req_state(rs),
    .o_pd_access(pa), .o_pd_out(po), .o_mbx_vld(mv), .o_mbx_proto(mp));
  sswd_top i_sswd_top (.i_clk(clk), .i_srst(srst), .i_req_vld(rv), .i_req_state(rs),
    .i_err_ack(ack), .i_mbx_cfg_ok(mok), .i_pd_cfg_ok(pok), .i_dc_cfg_ok(dok), .i_wd_load(ld),
    .i_wd_mult(mult), .i_wd_time(wt), .i_pd_access(pa), .i_pd_out(po), .i_phys_in(pin),
    .i_mbx_vld(mv), .i_mbx_proto(mp), .i_od_vld(ov), .i_od_wr(ow), .i_od_index(oi),
    .i_od_sub(os), .i_od_wdata(owd), .o_state(st), .o_err(err), .o_wd_fired(fired),
    .o_phys_out(pout), .o_in_shadow(sh), .o_mbx_acc(ma), .o_mbx_rej(mr), .o_pd_rej(pr),
    .o_od_ack(oa), .o_od_abort(ob), .o_od_rdata(rd));
  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic check(input string w, input logic [36:0] s, input logic [36:0] x);
    n_compared++;
    if (s !== x) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", w, x, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // object access with its note
  task automatic od(input logic w, input logic [15:0] i, input logic [31:0] v,
    input logic [37:0] x);
    @(posedge clk) #1;
    {ov, ow, oi, os, owd} = {1'b1, w, i, 8'h03, v};
    q.push_back(x);
    @(posedge clk) #1;
    ov = 1'b0;
  endtask
  // request then state, error, and error clear
  task automatic go(input logic [2:0] c, input logic [2:0] s, input logic f);
    i_sswd_master_model.req(c);
    check("state", st, s);
    check("error", err, f);
    @(posedge clk) #1 ack = 1'b1;
    @(posedge clk) #1 ack = 1'b0;
  endtask
  // answer watcher: oldest note against each pulse
  always @(posedge clk) begin
    #2;
    if (oa | ob | ma | mr | pr) begin
      e = q.size() > 0 ? q.pop_front() : 38'h0;
      check("answer", {oa, ob, ma, mr, pr, e[37] ? rd : 32'h0}, e[36:0]);
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    check("reset state", st, 3'h0);
    i_sswd_master_model.mbx(4'h1);
    q.push_back(MREJ);
    i_sswd_master_model.pd(8'hA5);
    q.push_back(PREJ);
    foreach (bad[i]) go(bad[i], 3'h0, 1'b1);
    $display("test init done");
    mok = 1'b1;
    go(sswd_pkg::REQ_BOOT, 3'h4, 1'b0);
    for (int p = 0; p < 8; p++) begin
      i_sswd_master_model.mbx(4'(p));
      q.push_back(4'(p) == sswd_pkg::MBX_FILE ? MACC : MREJ);
    end
    i_sswd_master_model.pd(8'($random(seed)));
    q.push_back(PREJ);
    go(sswd_pkg::REQ_PREOP, 3'h4, 1'b1);
    go(sswd_pkg::REQ_INIT, 3'h0, 1'b0);
    go(sswd_pkg::REQ_PREOP, 3'h1, 1'b0);
    i_sswd_master_model.mbx(4'h1);
    q.push_back(MACC);
    i_sswd_master_model.pd(8'h3C);
    q.push_back(PREJ);
    owd = $random(seed);
    od(1'b1, 16'h8000, owd, ACK);
    od(1'b0, 16'h4000, 32'h0, DAT | ACK | {6'h0, owd});
    od(1'b0, 16'h1000, 32'h0, DAT | ACK | {6'h0, sswd_pkg::DEV_TYPE});
    od(1'b1, 16'h1018, 32'h1, ABT);
    od(1'b1, 16'h6000, 32'h1, ABT);
    od(1'b0, 16'hFFFF, 32'h0, ABT);
    $display("test boot and preop done");
    dok = 1'b1;
    go(sswd_pkg::REQ_SAFEOP, 3'h1, 1'b1);
    pok = 1'b1;
    pin = 8'($random(seed));
    go(sswd_pkg::REQ_SAFEOP, 3'h2, 1'b0);
    check("input copy", sh, pin);
    i_sswd_master_model.pd(8'h5A);
    check("safe outputs", pout, 8'h00);
    go(sswd_pkg::REQ_OP, 3'h3, 1'b0);
    d = 8'($random(seed));
    i_sswd_master_model.pd(d);
    check("op outputs", pout, d);
    od(1'b0, 16'h7000, 32'h0, DAT | ACK | {30'h0, d});
    od(1'b0, 16'h6000, 32'h0, DAT | ACK | {30'h0, pin});
    $display("test safeop and op done");
    @(posedge clk) #1 ld = 1'b1;
    @(posedge clk) #1 ld = 1'b0;
    i_sswd_master_model.pd(d);
    repeat (10) @(posedge clk);
    #2 check("early fire", fired, 1'b0);
    for (n = 0; n < 30 && fired !== 1'b1; n++) @(posedge clk) #2;
    check("fired", fired, 1'b1);
    // two base ticks of 4 * (1 + 2) clocks after the load, 12 already waited
    check("fire cycle", n, 2 * sswd_pkg::BASE_DIV * 3 - 12);
    // outputs drop the cycle after the flag
    @(posedge clk) #2;
    check("cleared", pout, 8'h00);
    // the restarting access clears the flag; outputs follow the next access
    i_sswd_master_model.pd(~d);
    check("restart", {fired, pout}, 9'h000);
    i_sswd_master_model.pd(~d);
    check("resume", pout, 8'(~d));
    wt = 16'h0000;
    @(posedge clk) #1 ld = 1'b1;
    @(posedge clk) #1 ld = 1'b0;
    go(sswd_pkg::REQ_INIT, 3'h0, 1'b0);
    go(sswd_pkg::REQ_PREOP, 3'h1, 1'b0);
    go(sswd_pkg::REQ_SAFEOP, 3'h2, 1'b0);
    i_sswd_master_model.pd(d);
    repeat (40) @(posedge clk);
    #2 check("no watchdog", {fired, pout}, {1'b0, d});
    $display("test watchdog done");
    repeat (3) @(posedge clk);
    check("notes left", q.size(), 0);
    tally_and_finish();
  end
endmodule
bind sswd_top sswd_top_monitor i_sswd_top_monitor (.i_clk(i_clk), .i_srst(i_srst),
  .i_req_vld(i_req_vld), .i_req_state(i_req_state), .i_mbx_cfg_ok(i_mbx_cfg_ok),
  .i_pd_access(i_pd_access), .i_pd_out(i_pd_out), .i_mbx_vld(i_mbx_vld),
  .i_mbx_proto(i_mbx_proto), .i_od_vld(i_od_vld), .o_state(o_state), .o_err(o_err),
  .o_wd_fired(o_wd_fired), .o_phys_out(o_phys_out), .o_mbx_acc(o_mbx_acc),
  .o_mbx_rej(o_mbx_rej), .o_pd_rej(o_pd_rej), .o_od_ack(o_od_ack),
  .o_od_abort(o_od_abort));
`default_nettype wire
